// file: logic/dcpu_cfg.svh
// Purpose: constants for the dac clear, power and update control block
// Assumes: one 100 MHz clock, plain register port, word index addressing
// Notes: offsets are word indices on the register port
//
// Functional notes
// R1 - low clear pin clears main and sub dac of every channel
// R2 - main clear code gives midscale in twos complement, bottom in offset binary
// R3 - one written to system clear clears every main dac output
// R4 - channel clear hits only its main dac and acts on the next load
// R5 - sub dac cleared only by the pin, always to its midscale
// R6 - power down bit at zero powers off reference and dacs, one restores
// R7 - power down keeps every register value intact
// R8 - system standby sleeps all dacs, reference stays powered
// R9 - channel standby sleeps only that channel
// R10 - a load copies every input register into its output register together
// R11 - load level is sampled at the end of each data write
// R12 - load low at sampling updates outputs as part of that write
// R13 - host may hold load low or drive it with data timing
// R14 - load high at sampling defers update; host waits setup time first
// R15 - each channel has a 10 bit main dac and 8 bit sub dac
// R16 - four or eight channels
// R17 - one coding for all channels, offset binary after reset
// R18 - twos complement main code is signed, code zero is the bias point
// R19 - twos complement sub code is signed 8 bit
// R20 - in byte load mode a data bit picks main or sub per write
// R21 - system standby bit is one after reset and one means standby
// R22 - channel standby bit zero means standby, one normal
// R23 - a deferred update happens when load is driven low
`ifndef DCPU_CFG_SVH
`define DCPU_CFG_SVH

// ==========================================================
// timing
`define DCPU_CLK_PERIOD_NS 10
`define DCPU_LOAD_SETUP_NS 20
`define DCPU_LOAD_SETUP_CYC \
  ((`DCPU_LOAD_SETUP_NS + `DCPU_CLK_PERIOD_NS - 1) / `DCPU_CLK_PERIOD_NS)

// ==========================================================
// register map
`define DCPU_ADDR_SYS 8'h00
`define DCPU_ADDR_STAT 8'h40
`define DCPU_REG_CHCTRL 4'h1
`define DCPU_REG_MAIN 4'h2
`define DCPU_REG_SUB 4'h3
`define DCPU_REG_MOUT 4'h5
`define DCPU_REG_SOUT 4'h6
`define DCPU_REG_BYTE 4'h7

// ==========================================================
// fields
`define DCPU_SYS_CLR_BIT 0
`define DCPU_SYS_CHANNEL_STANDBY_N_BIT_BIT 1
`define DCPU_SYS_PD_N_BIT 2
`define DCPU_SYS_CODE_BIT 3
`define DCPU_SYS_BYTE_BIT 4
`define DCPU_CH_CLR_BIT 0
`define DCPU_CH_CHANNEL_STANDBY_N_BIT_N_BIT 1
`define DCPU_CH_MSEL_BIT 2
`define DCPU_CH_MUX_LSB 3
`define DCPU_BYTE_HALF_BIT 1
`define DCPU_BYTE_MSEL_BIT 0

// ==========================================================
// reset and clear values
`define DCPU_SYS_CHANNEL_STANDBY_N_BIT_RST 1'b1
`define DCPU_SYS_PD_N_RST 1'b1
`define DCPU_SYS_CODE_RST 1'b1
`define DCPU_SYS_BYTE_RST 1'b0
`define DCPU_CH_CLR_RST 1'b0
`define DCPU_CH_CHANNEL_STANDBY_N_BIT_N_RST 1'b1
`define DCPU_CH_MSEL_RST 1'b0
`define DCPU_CH_MUX_RST 2'h0
`define DCPU_MAIN_CLR_TWOS 10'h000
`define DCPU_MAIN_CLR_OBIN 10'h000
`define DCPU_SUB_CLR_TWOS 8'h00
`define DCPU_SUB_CLR_OBIN 8'h80
`define DCPU_MAIN_SIGN 10'h200
`define DCPU_SUB_SIGN 8'h80

`endif

// file: logic/dcpu_pkg.sv
// Purpose: types for the dac clear, power and update control block
// Assumes: nothing beyond the cfg header
// Notes: load sequencing states only
package dcpu_pkg;

  // ==========================================================
  // deferred load sequencing
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_SETUP = 2'b01,
    LD_ARMED = 2'b10
  } dcpu_load_t;

endpackage

// file: logic/dcpu_ctrl.sv
// Purpose: clear, power-down, standby and output update control for a dac bank
// Assumes: inputs synchronous to CLK, NUM_CH is 4 or 8
// Notes: levels on MAIN_LEVEL and SUB_LEVEL are offset binary whatever the coding
`include "dcpu_cfg.svh"

module dcpu_ctrl #(
  // quad or octal bank; other counts leave index bits undecoded [R16]
  parameter int NUM_CH = 8,
  parameter int LOAD_SETUP_CYC = `DCPU_LOAD_SETUP_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic CLEAR_N,
  input wire logic LOAD_OUTPUTS_N,
  output logic [NUM_CH*10-1:0] MAIN_LEVEL,
  output logic [NUM_CH*8-1:0] SUB_LEVEL,
  output logic [NUM_CH-1:0] CH_ACTIVE,
  output logic [NUM_CH*2-1:0] BIAS_SEL,
  output logic REF_ON
);

  // ==========================================================
  // sizing
  // channel index width follows the bank size [R16]
  localparam int CH_W = $clog2(NUM_CH);

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // decode
  // address split: upper nibble picks the register kind, lower the channel
  logic [3:0] region;
  logic [CH_W-1:0] ch_idx;
  logic ch_ok;

  // write qualifiers, one per writable register kind
  logic wr_sys;
  logic wr_chc;
  logic wr_dat;
  logic wr_byt;
  logic data_wr;

  // clear sources and the codes they force
  logic sys_clr;
  logic hw_clr;
  logic coding_eff;
  logic [9:0] clr_main;
  logic [7:0] clr_sub;

  // system control state
  logic sys_channel_standby_n_bit_q;
  logic pd_n_q;
  logic coding_q;
  logic byte_mode_q;

  // channel control state, one entry per channel [R16]
  logic [NUM_CH-1:0] ch_clr_q;
  logic [NUM_CH-1:0] ch_channel_standby_n_bit_n_q;
  logic [NUM_CH-1:0] ch_msel_q;
  logic [1:0] ch_mux_q [NUM_CH];

  assign region = ADDR[7:4];
  assign ch_idx = ADDR[CH_W-1:0];
  assign ch_ok = ((ADDR[3:0] >> CH_W) == 4'h0);
  assign wr_sys = WR && (ADDR == `DCPU_ADDR_SYS);
  assign wr_chc = WR && (region == `DCPU_REG_CHCTRL) && ch_ok;
  // the two loading structures are exclusive so a stray write cannot land twice
  assign wr_dat = WR && (region == `DCPU_REG_MAIN) && ch_ok && !byte_mode_q;
  assign wr_byt = WR && (region == `DCPU_REG_BYTE) && ch_ok && byte_mode_q;
  assign data_wr = wr_dat || wr_byt;
  assign sys_clr = wr_sys && WDATA[`DCPU_SYS_CLR_BIT]; // [R3]
  assign hw_clr = !CLEAR_N; // [R1]
  // a clear written with a new coding uses the new coding
  assign coding_eff = wr_sys ? WDATA[`DCPU_SYS_CODE_BIT] : coding_q;
  assign clr_main = coding_eff ? `DCPU_MAIN_CLR_OBIN : `DCPU_MAIN_CLR_TWOS; // [R2]
  assign clr_sub = coding_eff ? `DCPU_SUB_CLR_OBIN : `DCPU_SUB_CLR_TWOS; // [R5]

  // ==========================================================
  // system control
  // power down only gates outputs; nothing here is reset by it [R7]
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sys_channel_standby_n_bit_q <= `DCPU_SYS_CHANNEL_STANDBY_N_BIT_RST; // [R21]
      pd_n_q <= `DCPU_SYS_PD_N_RST;
      coding_q <= `DCPU_SYS_CODE_RST; // [R17]
      byte_mode_q <= `DCPU_SYS_BYTE_RST;
    end else if (wr_sys) begin
      sys_channel_standby_n_bit_q <= WDATA[`DCPU_SYS_CHANNEL_STANDBY_N_BIT_BIT];
      pd_n_q <= WDATA[`DCPU_SYS_PD_N_BIT]; // [R6]
      coding_q <= WDATA[`DCPU_SYS_CODE_BIT]; // [R17]
      byte_mode_q <= WDATA[`DCPU_SYS_BYTE_BIT];
    end
  end

  // ==========================================================
  // channel control
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ch_clr_q <= {NUM_CH{`DCPU_CH_CLR_RST}};
      ch_channel_standby_n_bit_n_q <= {NUM_CH{`DCPU_CH_CHANNEL_STANDBY_N_BIT_N_RST}};
      ch_msel_q <= {NUM_CH{`DCPU_CH_MSEL_RST}};
      for (int i = 0; i < NUM_CH; i++) begin
        ch_mux_q[i] <= `DCPU_CH_MUX_RST;
      end
    end else if (wr_chc) begin
      ch_clr_q[ch_idx] <= WDATA[`DCPU_CH_CLR_BIT]; // [R4]
      ch_channel_standby_n_bit_n_q[ch_idx] <= WDATA[`DCPU_CH_CHANNEL_STANDBY_N_BIT_N_BIT]; // [R9]
      ch_msel_q[ch_idx] <= WDATA[`DCPU_CH_MSEL_BIT];
      ch_mux_q[ch_idx] <= WDATA[`DCPU_CH_MUX_LSB +: 2];
    end
  end

  // ==========================================================
  // input data registers
  logic [9:0] main_in_q [NUM_CH]; // [R15]
  logic [7:0] sub_in_q [NUM_CH]; // [R15]

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NUM_CH; i++) begin
        main_in_q[i] <= `DCPU_MAIN_CLR_OBIN;
        sub_in_q[i] <= `DCPU_SUB_CLR_OBIN;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hw_clr) begin
          // inputs cleared too so a later load cannot bring old data back [R1]
          main_in_q[i] <= clr_main;
          sub_in_q[i] <= clr_sub; // [R5]
        end else if (sys_clr) begin
          main_in_q[i] <= clr_main; // [R3]
        end else if (wr_dat && (ch_idx == CH_W'(i))) begin
          if (ch_msel_q[i]) begin
            sub_in_q[i] <= WDATA[7:0];
          end else begin
            main_in_q[i] <= WDATA[9:0];
          end
        end else if (wr_byt && (ch_idx == CH_W'(i))) begin
          if (WDATA[`DCPU_BYTE_MSEL_BIT]) begin // [R20]
            if (!WDATA[`DCPU_BYTE_HALF_BIT]) begin
              sub_in_q[i] <= WDATA[9:2];
            end
          end else if (!WDATA[`DCPU_BYTE_HALF_BIT]) begin
            main_in_q[i][9:2] <= WDATA[9:2];
          end else begin
            main_in_q[i][1:0] <= WDATA[3:2];
          end
        end
      end
    end
  end

  // ==========================================================
  // load sequencing
  dcpu_pkg::dcpu_load_t ld_state_q;
  logic [7:0] setup_cnt_q;
  logic load_n_prev_q;
  logic load_fall;
  logic load_req;
  logic load_pulse_q;

  assign load_fall = load_n_prev_q && !LOAD_OUTPUTS_N;

  always_comb begin
    load_req = 1'b0;
    if (data_wr) begin
      load_req = !LOAD_OUTPUTS_N; // [R11] [R12] [R13]
    end else begin
      unique case (ld_state_q)
        dcpu_pkg::LD_IDLE: begin
          load_req = load_fall; // [R10]
        end
        dcpu_pkg::LD_SETUP: begin
          load_req = 1'b0; // [R14]
        end
        dcpu_pkg::LD_ARMED: begin
          load_req = !LOAD_OUTPUTS_N; // [R23]
        end
        default: begin
          load_req = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_n_prev_q <= 1'b1;
    end else begin
      load_n_prev_q <= LOAD_OUTPUTS_N;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ld_state_q <= dcpu_pkg::LD_IDLE;
      setup_cnt_q <= 8'h00;
    end else if (data_wr) begin
      if (LOAD_OUTPUTS_N) begin
        // a new deferred write restarts the setup wait [R14]
        ld_state_q <= dcpu_pkg::LD_SETUP;
        setup_cnt_q <= 8'(LOAD_SETUP_CYC - 1);
      end else begin
        ld_state_q <= dcpu_pkg::LD_IDLE; // [R12]
      end
    end else begin
      unique case (ld_state_q)
        dcpu_pkg::LD_IDLE: begin
          ld_state_q <= dcpu_pkg::LD_IDLE;
        end
        dcpu_pkg::LD_SETUP: begin
          if (setup_cnt_q == 8'h00) begin
            ld_state_q <= dcpu_pkg::LD_ARMED;
          end else begin
            setup_cnt_q <= setup_cnt_q - 8'h01;
          end
        end
        dcpu_pkg::LD_ARMED: begin
          if (!LOAD_OUTPUTS_N) begin
            ld_state_q <= dcpu_pkg::LD_IDLE; // [R23]
          end
        end
        default: begin
          ld_state_q <= dcpu_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // applied one cycle later so the written word is already in its input register
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_pulse_q <= 1'b0;
    end else begin
      load_pulse_q <= load_req;
    end
  end

  // ==========================================================
  // output dac registers
  logic [9:0] main_out_q [NUM_CH];
  logic [7:0] sub_out_q [NUM_CH];

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NUM_CH; i++) begin
        main_out_q[i] <= `DCPU_MAIN_CLR_OBIN;
        sub_out_q[i] <= `DCPU_SUB_CLR_OBIN;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hw_clr) begin
          main_out_q[i] <= clr_main; // [R1] [R2]
          sub_out_q[i] <= clr_sub; // [R5]
        end else begin
          if (sys_clr) begin
            main_out_q[i] <= clr_main; // [R3]
          end else if (load_pulse_q) begin
            // every channel moves in the same edge [R10]
            main_out_q[i] <= ch_clr_q[i] ? clr_main : main_in_q[i]; // [R4]
          end
          if (load_pulse_q) begin
            sub_out_q[i] <= sub_in_q[i]; // [R10]
          end
        end
      end
    end
  end

  // ==========================================================
  // analogue facing levels and power
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      MAIN_LEVEL <= '0;
      SUB_LEVEL <= {NUM_CH{`DCPU_SUB_CLR_OBIN}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // flipping the sign bit maps signed code zero onto the bias point
        MAIN_LEVEL[i*10 +: 10] <= coding_q ? main_out_q[i]
                                           : (main_out_q[i] ^ `DCPU_MAIN_SIGN); // [R18]
        SUB_LEVEL[i*8 +: 8] <= coding_q ? sub_out_q[i]
                                        : (sub_out_q[i] ^ `DCPU_SUB_SIGN); // [R19]
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      REF_ON <= 1'b0;
      CH_ACTIVE <= '0;
      BIAS_SEL <= '0;
    end else begin
      REF_ON <= pd_n_q; // [R6] [R8]
      for (int i = 0; i < NUM_CH; i++) begin
        CH_ACTIVE[i] <= pd_n_q && !sys_channel_standby_n_bit_q && ch_channel_standby_n_bit_n_q[i]; // [R6] [R8] [R9] [R22]
        BIAS_SEL[i*2 +: 2] <= ch_mux_q[i];
      end
    end
  end

  // ==========================================================
  // read back
  logic [15:0] rd_val;
  logic [15:0] stat_val;

  // status is read only; a write to its address is ignored
  always_comb begin
    stat_val = 16'h0000;
    stat_val[0] = (ld_state_q != dcpu_pkg::LD_IDLE);
    stat_val[1] = (ld_state_q == dcpu_pkg::LD_ARMED);
    stat_val[2] = hw_clr;
    stat_val[3] = REF_ON;
    stat_val[8 +: NUM_CH] = CH_ACTIVE;
  end

  always_comb begin
    rd_val = 16'h0000;
    if (ADDR == `DCPU_ADDR_SYS) begin
      // system clear is a strobe and reads back as zero
      rd_val[`DCPU_SYS_CHANNEL_STANDBY_N_BIT_BIT] = sys_channel_standby_n_bit_q;
      rd_val[`DCPU_SYS_PD_N_BIT] = pd_n_q;
      rd_val[`DCPU_SYS_CODE_BIT] = coding_q;
      rd_val[`DCPU_SYS_BYTE_BIT] = byte_mode_q;
    end else if (ADDR == `DCPU_ADDR_STAT) begin
      rd_val = stat_val;
    end else if (ch_ok) begin
      unique case (region)
        `DCPU_REG_CHCTRL: begin
          rd_val[`DCPU_CH_CLR_BIT] = ch_clr_q[ch_idx];
          rd_val[`DCPU_CH_CHANNEL_STANDBY_N_BIT_N_BIT] = ch_channel_standby_n_bit_n_q[ch_idx];
          rd_val[`DCPU_CH_MSEL_BIT] = ch_msel_q[ch_idx];
          rd_val[`DCPU_CH_MUX_LSB +: 2] = ch_mux_q[ch_idx];
        end
        `DCPU_REG_MAIN: rd_val[9:0] = main_in_q[ch_idx];
        `DCPU_REG_SUB: rd_val[7:0] = sub_in_q[ch_idx];
        `DCPU_REG_MOUT: rd_val[9:0] = main_out_q[ch_idx];
        `DCPU_REG_SOUT: rd_val[7:0] = sub_out_q[ch_idx];
        default: rd_val = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rd_val : 16'h0000;
    end
  end

endmodule

// file: tb/dcpu_ctrl_assertions.sv
// Purpose: port checks for the dac control block
// Assumes: bench keeps clears and loads apart
// Notes: coding and byte mode mirrored from writes
module dcpu_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic CLEAR_N,
  input wire logic LOAD_OUTPUTS_N,
  input wire logic [NUM_CH*10-1:0] MAIN_LEVEL,
  input wire logic [NUM_CH*8-1:0] SUB_LEVEL,
  input wire logic [NUM_CH-1:0] CH_ACTIVE,
  input wire logic REF_ON
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // mirrors
  logic cod_q;
  logic byte_q;
  logic sys_wr;
  assign sys_wr = WR && ADDR == 8'h00;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cod_q <= 1'b1;
      byte_q <= 1'b0;
    end else if (sys_wr) begin
      cod_q <= WDATA[3];
      byte_q <= WDATA[4];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ====================
  // properties
  sequence s_main_wr;
    WR && ADDR == 8'h20 && !byte_q && CLEAR_N;
  endsequence
  property p_ref;
    sys_wr |-> ##2 REF_ON == $past(WDATA[2], 2);
  endproperty
  property p_pd;
    sys_wr && !WDATA[2] |-> ##2 CH_ACTIVE == '0;
  endproperty
  property p_channel_standby_n_bit;
    sys_wr && WDATA[1] |-> ##2 CH_ACTIVE == '0 && REF_ON == $past(WDATA[2], 2);
  endproperty
  property p_clr_sub;
    !CLEAR_N |-> ##2 SUB_LEVEL == {NUM_CH{8'h80}};
  endproperty
  property p_clr_main;
    !CLEAR_N |-> ##2 MAIN_LEVEL == {NUM_CH{cod_q ? 10'h000 : 10'h200}};
  endproperty
  property p_sysclr;
    sys_wr && WDATA[0] && CLEAR_N |-> ##2 $stable(SUB_LEVEL)
      && MAIN_LEVEL == {NUM_CH{$past(WDATA[3], 2) ? 10'h000 : 10'h200}};
  endproperty
  // levels are offset binary, so twos codes flip the sign bit
  property p_sync;
    s_main_wr ##0 !LOAD_OUTPUTS_N |-> ##3
      MAIN_LEVEL[9:0] == ($past(WDATA[9:0], 3) ^ (cod_q ? 10'h000 : 10'h200));
  endproperty
  property p_defer;
    s_main_wr ##0 LOAD_OUTPUTS_N |-> ##2 $stable(MAIN_LEVEL) [*2];
  endproperty
  a_ref: assert property (p_ref) else $error("ref level wrong");
  a_pd: assert property (p_pd) else $error("active in power down");
  a_channel_standby_n_bit: assert property (p_channel_standby_n_bit) else $error("standby wrong");
  a_clr_sub: assert property (p_clr_sub) else $error("sub not cleared");
  a_clr_main: assert property (p_clr_main) else $error("main not cleared");
  a_sysclr: assert property (p_sysclr) else $error("system clear wrong");
  a_sync: assert property (p_sync) else $error("sync load wrong");
  a_defer: assert property (p_defer) else $error("early update");
endmodule

bind dcpu_ctrl dcpu_chk #(.NUM_CH(NUM_CH)) dcpu_chk_i (
  .CLK(CLK),
  .RSTN(RSTN),
  .ADDR(ADDR),
  .WDATA(WDATA),
  .WR(WR),
  .CLEAR_N(CLEAR_N),
  .LOAD_OUTPUTS_N(LOAD_OUTPUTS_N),
  .MAIN_LEVEL(MAIN_LEVEL),
  .SUB_LEVEL(SUB_LEVEL),
  .CH_ACTIVE(CH_ACTIVE),
  .REF_ON(REF_ON)
);

// file: tb/dcpu_host.sv
// Purpose: host model on the register port and strobes
// Assumes: every change follows a rising edge
// Notes: released lines show inverted data, never stale
module dcpu_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  output logic clear_n,
  output logic load_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    clear_n = 1'b1;
    load_n = 1'b1;
  end
  // load moves with the data, like any other data input
  task automatic wrt(input logic [7:0] a, input logic [15:0] d, input logic l);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    load_n <= l;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
  endtask
  task automatic ld(input logic l);
    @(posedge clk);
    load_n <= l;
  endtask
  task automatic clr();
    @(posedge clk);
    clear_n <= 1'b0;
    @(posedge clk);
    clear_n <= 1'b1;
  endtask
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the dac control block
// Assumes: four channels, two cycle load setup
// Notes: reads are checked against a queue of expected values
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NC = 4;
  localparam int LSC = 2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic clear_n;
  logic load_n;
  logic [15:0] RDATA;
  logic [NC*10-1:0] MAIN_LEVEL;
  logic [NC*8-1:0] SUB_LEVEL;
  logic [NC-1:0] CH_ACTIVE;
  logic [NC*2-1:0] BIAS_SEL;
  logic REF_ON;
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h00000063;
  logic [9:0] m [NC];
  always #5 clk = ~clk;
  dcpu_host dcpu_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .clear_n(clear_n), .load_n(load_n));
  dcpu_ctrl #(.NUM_CH(NC), .LOAD_SETUP_CYC(LSC)) dcpu_ctrl_i (.CLK(clk), .RSTN(rstn),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(RDATA), .CLEAR_N(clear_n),
    .LOAD_OUTPUTS_N(load_n), .MAIN_LEVEL(MAIN_LEVEL), .SUB_LEVEL(SUB_LEVEL),
    .CH_ACTIVE(CH_ACTIVE), .BIAS_SEL(BIAS_SEL), .REF_ON(REF_ON));
  // ====================
  // checking
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rd_x(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    dcpu_host_i.rdt(a);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic results();
    $display("counts comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // read data stands one cycle only, so take it at the next edge
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(40'(RDATA), 40'(exp_q.pop_front()));
    end
    rd_seen = rd;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
  // ====================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(40'({REF_ON, CH_ACTIVE}), 40'h10);
    rd_x(8'h00, 16'h000E);
    rd_x(8'h11, 16'h0002);
    rd_x(8'h61, 16'h0080);
    rd_x(8'h80, 16'h0000);
    $display("done reset");
    dcpu_host_i.wrt(8'h00, 16'h000C, 1'b1);
    settle();
    chk(40'(CH_ACTIVE), 40'hF);
    dcpu_host_i.wrt(8'h12, 16'h0000, 1'b1);
    settle();
    chk(40'(CH_ACTIVE), 40'hB);
    dcpu_host_i.wrt(8'h00, 16'h0008, 1'b1);
    settle();
    chk(40'({REF_ON, CH_ACTIVE}), 40'h00);
    rd_x(8'h12, 16'h0000);
    dcpu_host_i.wrt(8'h00, 16'h000C, 1'b1);
    settle();
    chk(40'({REF_ON, CH_ACTIVE}), 40'h1B);
    dcpu_host_i.wrt(8'h00, 16'h000E, 1'b1);
    settle();
    chk(40'({REF_ON, CH_ACTIVE}), 40'h10);
    dcpu_host_i.wrt(8'h12, 16'h0002, 1'b1);
    dcpu_host_i.wrt(8'h00, 16'h000C, 1'b1);
    dcpu_host_i.wrt(8'h10, 16'h0012, 1'b1);
    settle();
    chk(40'({CH_ACTIVE, BIAS_SEL}), 40'hF02);
    $display("done power");
    for (int i = 0; i < NC; i++) begin
      m[i] = 10'(rnd());
      dcpu_host_i.wrt(8'h20 + 8'(i), {6'h00, m[i]}, 1'b0);
      rd_x(8'h50 + 8'(i), {6'h00, m[i]});
    end
    dcpu_host_i.wrt(8'h20, 16'h0155, 1'b1);
    dcpu_host_i.wrt(8'h21, 16'h02AA, 1'b1);
    rd_x(8'h50, {6'h00, m[0]});
    repeat (LSC) @(posedge clk);
    dcpu_host_i.ld(1'b0);
    settle();
    rd_x(8'h50, 16'h0155);
    rd_x(8'h51, 16'h02AA);
    dcpu_host_i.ld(1'b1);
    $display("done loads");
    dcpu_host_i.wrt(8'h13, 16'h0003, 1'b1);
    rd_x(8'h53, {6'h00, m[3]});
    dcpu_host_i.ld(1'b0);
    settle();
    rd_x(8'h53, 16'h0000);
    rd_x(8'h52, {6'h00, m[2]});
    dcpu_host_i.ld(1'b1);
    dcpu_host_i.wrt(8'h13, 16'h0002, 1'b1);
    $display("done channel clear");
    dcpu_host_i.wrt(8'h11, 16'h0006, 1'b1);
    dcpu_host_i.wrt(8'h21, 16'h00AB, 1'b0);
    rd_x(8'h61, 16'h00AB);
    dcpu_host_i.wrt(8'h11, 16'h0002, 1'b1);
    dcpu_host_i.wrt(8'h00, 16'h000D, 1'b1);
    rd_x(8'h50, 16'h0000);
    rd_x(8'h61, 16'h00AB);
    dcpu_host_i.clr();
    rd_x(8'h61, 16'h0080);
    dcpu_host_i.wrt(8'h00, 16'h0004, 1'b1);
    dcpu_host_i.clr();
    settle();
    chk(MAIN_LEVEL, {NC{10'h200}});
    chk(40'(SUB_LEVEL), 40'({NC{8'h80}}));
    rd_x(8'h61, 16'h0000);
    dcpu_host_i.wrt(8'h20, 16'h03FF, 1'b0);
    settle();
    chk(40'(MAIN_LEVEL[9:0]), 40'h1FF);
    dcpu_host_i.wrt(8'h11, 16'h0006, 1'b1);
    dcpu_host_i.wrt(8'h21, 16'h007F, 1'b0);
    settle();
    chk(40'(SUB_LEVEL[15:8]), 40'hFF);
    dcpu_host_i.wrt(8'h11, 16'h0002, 1'b1);
    $display("done clears");
    dcpu_host_i.wrt(8'h00, 16'h001C, 1'b1);
    dcpu_host_i.wrt(8'h72, 16'h02AC, 1'b1);
    dcpu_host_i.wrt(8'h72, 16'h000E, 1'b0);
    dcpu_host_i.wrt(8'h73, 16'h0155, 1'b0);
    dcpu_host_i.wrt(8'h22, 16'h0111, 1'b0);
    rd_x(8'h52, 16'h02AF);
    rd_x(8'h33, 16'h0055);
    rd_x(8'h22, 16'h02AF);
    settle();
    $display("done byte mode");
    results();
  end
endmodule
